// [logic/overlay_config_crawl_cmd.sv]
// Behaviour
// - Crawl copies string; empty string disables crawl
// - Argument one: zero stops, one runs
// - Crawl line pixels, negative from bottom, -22
// - Crawl advance per field, default two
// - Gap percent 0..100 default 70, repeats
// - Latch font and render mode at start
// - Crawl survives clears and mode changes
// - Deferred clear on next non-NUL character
// - Settings volatile until selector one saves
// - Selector two restores factory defaults, script
// - Selector eight captures script, max 900
// - Selector nine sets legacy lockout, default one
// - Selector eleven maps CR and LF
// - Sixteen picks standard; nineteen auto adopts, saves
// - Seventeen picks progressive or interlaced scan
// - Eighteen picks local, remote or automatic source
// - High-rate option sets default pixel clock
// - Nonzero pixel select overrides, sets line width
// - Twenty-one constrains display about thirteen percent
// - Horizontal start, width; defaults, step, clamp
// - Vertical start, height; defaults, clamp
// - Twenty-eight blanks overlay, memory still drawn
`timescale 1ns/1ps
`include "overlay_cfg_regs.svh"

module overlay_config_crawl_cmd (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Decoded command from the escape parser
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_argc,
  input wire logic [15:0] cmd_arg0,
  input wire logic [15:0] cmd_arg1,
  input wire logic [15:0] cmd_arg2,
  input wire logic [15:0] cmd_arg3,
  input wire logic [15:0] cmd_arg4,
  // Printable character stream
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  // Drawing context and string buffer state
  input wire logic [9:0] str_len,
  input wire logic [3:0] cur_font,
  input wire logic [6:0] cur_render,
  // Video detector
  input wire logic det_valid,
  input wire logic det_pal,
  input wire logic local_active,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Character stream out
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_cr,
  output logic out_lf,
  output logic clear_screen,
  // Buffer and flash requests
  output logic crawl_copy,
  output logic boot_copy,
  output logic [9:0] boot_len,
  output logic flash_save,
  output logic factory_load,
  // Crawl settings
  output logic crawl_on,
  output logic [15:0] crawl_line,
  output logic [15:0] crawl_rate,
  output logic [6:0] crawl_gap,
  output logic [15:0] crawl_reps,
  output logic crawl_forever,
  output logic [3:0] crawl_font,
  output logic [6:0] crawl_render,
  // Video configuration
  output logic [15:0] cfg_word,
  output logic [3:0] pixel_clock_select,
  output logic [9:0] line_pixels,
  output logic [9:0] hstart,
  output logic [9:0] hsize,
  output logic [9:0] vstart,
  output logic [9:0] vsize
);

  // ==========
  // Helper functions

  // Pixel clock in kHz from select code and standard
  function automatic logic [13:0] rate_khz(input logic [3:0] sel, input logic maxr,
                                           input logic pal);
    logic [13:0] r;
    r = pal ? `RATE_PAL_KHZ : `RATE_NTSC_KHZ;
    if (maxr)
      r = `RATE_MAX_KHZ;
    unique case (sel)
      4'h1: r = 14'd5000;
      4'h2: r = 14'd5375;
      4'h3: r = 14'd5769;
      4'h4: r = 14'd6250;
      4'h5: r = 14'd6818;
      4'h6: r = 14'd7500;
      4'h7: r = 14'd8330;
      4'h8: r = `RATE_MAX_KHZ;
      default: r = r;
    endcase
    return r;
  endfunction

  // Pixels per line: rate divided by 19.53125 kHz
  function automatic logic [9:0] pix_per_line(input logic [13:0] khz);
    logic [23:0] p;
    p = 24'(khz) * 24'(`PPL_MUL) / 24'(`PPL_DIV);
    return p[9:0];
  endfunction

  // Shrinks a span to the safe area when constrained
  function automatic logic [9:0] shrink(input logic [9:0] v, input logic con);
    logic [17:0] p;
    p = 18'(v) * 18'(`CONSTRAIN_PCT) / 18'd100;
    return con ? p[9:0] : v;
  endfunction

  // Clamps a request, zero picks the default
  function automatic logic [9:0] pick(input logic [9:0] req, input logic [9:0] def,
                                      input logic [9:0] lim);
    logic [9:0] v;
    v = (req == 10'h000) ? def : req;
    return (v > lim) ? lim : v;
  endfunction

  // Signed argument to an unsigned window value
  function automatic logic [9:0] arg10(input logic [15:0] a);
    logic [9:0] v;
    v = (a[15] || a[15:10] != 6'h00) ? (a[15] ? 10'h000 : 10'h3FF) : a[9:0];
    return v;
  endfunction

  // ==========
  // Configuration and crawl state
  logic overlay_ff, nxt_overlay;
  logic constrain_ff, nxt_constrain;
  logic pal_ff, nxt_pal;
  logic interlace_ff, nxt_interlace;
  logic auto_std_ff, nxt_auto_std;
  logic max_rate_ff, nxt_max_rate;
  logic legacy_lock_ff, nxt_legacy_lock;
  logic [1:0] crlf_ff, nxt_crlf;
  overlay_cfg_pkg::src_mode_t src_ff, nxt_src;
  logic [3:0] pixsel_ff, nxt_pixsel;
  logic [9:0] hstart_req_ff, nxt_hstart_req;
  logic [9:0] hsize_req_ff, nxt_hsize_req;
  logic [9:0] vstart_req_ff, nxt_vstart_req;
  logic [9:0] vsize_req_ff, nxt_vsize_req;
  logic [9:0] boot_len_ff, nxt_boot_len;
  logic save_ff, nxt_save;
  logic factory_ff, nxt_factory;
  logic boot_copy_ff, nxt_boot_copy;
  logic crawl_copy_ff, nxt_crawl_copy;
  logic crawl_on_ff, nxt_crawl_on;
  logic [15:0] crawl_line_ff, nxt_crawl_line;
  logic [15:0] crawl_rate_ff, nxt_crawl_rate;
  logic [6:0] crawl_gap_ff, nxt_crawl_gap;
  logic [15:0] crawl_reps_ff, nxt_crawl_reps;
  logic crawl_forever_ff, nxt_crawl_forever;
  logic [3:0] crawl_font_ff, nxt_crawl_font;
  logic [6:0] crawl_render_ff, nxt_crawl_render;
  logic [9:0] ppl_ff, nxt_ppl;
  logic [9:0] hstart_ff, nxt_hstart;
  logic [9:0] hsize_ff, nxt_hsize;
  logic [9:0] vstart_ff, nxt_vstart;
  logic [9:0] vsize_ff, nxt_vsize;
  logic [15:0] cfg_word_ff, nxt_cfg_word;

  overlay_cfg_pkg::cmd_op_t op;
  logic is_cfg;
  logic [7:0] sel;
  logic [15:0] m;
  logic [9:0] lines_total, hlim, vdef;
  logic [15:0] cur_cfg;

  assign op = overlay_cfg_pkg::cmd_op_t'(cmd_op);
  assign is_cfg = cmd_valid && op == overlay_cfg_pkg::OP_CONFIG;
  assign sel = cmd_arg0[7:0];
  assign m = cmd_arg1;

  // Current flags packed for the register view
  always_comb
  begin
    cur_cfg = 16'h0000;
    cur_cfg[`CF_OVERLAY] = overlay_ff;
    cur_cfg[`CF_CONSTRAIN] = constrain_ff;
    cur_cfg[`CF_PAL] = pal_ff;
    cur_cfg[`CF_INTERLACE] = interlace_ff;
    cur_cfg[`CF_AUTO_STD] = auto_std_ff;
    cur_cfg[`CF_MAX_RATE] = max_rate_ff;
    cur_cfg[`CF_LEGACY_LOCK] = legacy_lock_ff;
    cur_cfg[`CF_CRLF_LO +: 2] = crlf_ff;
    cur_cfg[`CF_SRC_LO +: 2] = src_ff;
  end

  // Next configuration and crawl values
  always_comb
  begin
    nxt_overlay = overlay_ff;
    nxt_constrain = constrain_ff;
    nxt_pal = pal_ff;
    nxt_interlace = interlace_ff;
    nxt_auto_std = auto_std_ff;
    nxt_max_rate = max_rate_ff;
    nxt_legacy_lock = legacy_lock_ff;
    nxt_crlf = crlf_ff;
    nxt_src = src_ff;
    nxt_pixsel = pixsel_ff;
    nxt_hstart_req = hstart_req_ff;
    nxt_hsize_req = hsize_req_ff;
    nxt_vstart_req = vstart_req_ff;
    nxt_vsize_req = vsize_req_ff;
    nxt_boot_len = boot_len_ff;
    nxt_save = 1'b0;
    nxt_factory = 1'b0;
    nxt_boot_copy = 1'b0;
    nxt_crawl_copy = 1'b0;
    nxt_crawl_on = crawl_on_ff;
    nxt_crawl_line = crawl_line_ff;
    nxt_crawl_rate = crawl_rate_ff;
    nxt_crawl_gap = crawl_gap_ff;
    nxt_crawl_reps = crawl_reps_ff;
    nxt_crawl_forever = crawl_forever_ff;
    nxt_crawl_font = crawl_font_ff;
    nxt_crawl_render = crawl_render_ff;
    if (cmd_valid && op == overlay_cfg_pkg::OP_CRAWL)
    begin
      if (str_len == 10'h000)
        nxt_crawl_on = 1'b0;
      else
      begin
        nxt_crawl_on = (cmd_argc == 3'd0) || (cmd_arg0 != 16'h0000);
        nxt_crawl_copy = nxt_crawl_on;
        nxt_crawl_line = (cmd_argc > 3'd1) ? cmd_arg1 : `CRAWL_DEF_LINE;
        nxt_crawl_rate = (cmd_argc > 3'd2) ? cmd_arg2 : `CRAWL_DEF_RATE;
        nxt_crawl_gap = `CRAWL_DEF_GAP;
        if (cmd_argc > 3'd3)
          nxt_crawl_gap = (cmd_arg3 > 16'(`CRAWL_GAP_MAX)) ? `CRAWL_GAP_MAX : cmd_arg3[6:0];
        nxt_crawl_forever = (cmd_argc < 3'd5);
        nxt_crawl_reps = (cmd_argc > 3'd4) ? cmd_arg4 : 16'h0000;
        if (nxt_crawl_on)
        begin
          nxt_crawl_font = cur_font;
          nxt_crawl_render = cur_render;
        end
      end
    end
    if (is_cfg)
    begin
      unique case (sel)
        `SEL_SAVE: nxt_save = 1'b1;
        `SEL_FACTORY:
        begin
          nxt_factory = 1'b1;
          nxt_overlay = 1'b1;
          nxt_constrain = 1'b1;
          nxt_pal = 1'b0;
          nxt_interlace = 1'b0;
          nxt_auto_std = 1'b1;
          nxt_max_rate = 1'b1;
          nxt_legacy_lock = 1'b1;
          nxt_crlf = 2'h0;
          nxt_src = overlay_cfg_pkg::SRC_AUTO;
          nxt_pixsel = 4'h0;
          nxt_hstart_req = 10'h000;
          nxt_hsize_req = 10'h000;
          nxt_vstart_req = 10'h000;
          nxt_vsize_req = 10'h000;
          nxt_boot_len = 10'h000;
        end
        `SEL_BOOT:
        begin
          nxt_boot_copy = 1'b1;
          nxt_boot_len = (str_len > `BOOT_MAX_LEN) ? `BOOT_MAX_LEN : str_len;
        end
        `SEL_LEGACY: nxt_legacy_lock = m[0];
        `SEL_CRLF: nxt_crlf = m[1:0];
        `SEL_STD: nxt_pal = m[0];
        `SEL_SCAN: nxt_interlace = m[0];
        `SEL_SOURCE:
          if (m >= 16'h0001 && m <= 16'h0003)
            nxt_src = overlay_cfg_pkg::src_mode_t'(m[1:0]);
        `SEL_AUTO_STD: nxt_auto_std = m[0];
        `SEL_MAX_RATE: nxt_max_rate = m[0];
        `SEL_CONSTRAIN: nxt_constrain = m[0];
        `SEL_PIXSEL:
          if (m <= 16'h0008)
            nxt_pixsel = m[3:0];
        `SEL_HSTART: nxt_hstart_req = arg10(m);
        `SEL_HSIZE: nxt_hsize_req = arg10(m);
        `SEL_VSTART: nxt_vstart_req = arg10(m);
        `SEL_VSIZE: nxt_vsize_req = arg10(m);
        `SEL_OVERLAY: nxt_overlay = m[0];
        default: nxt_save = 1'b0;
      endcase
    end
    // Software write of the config word
    if (reg_wr && reg_addr == `OFS_CONFIG)
    begin
      nxt_overlay = reg_wdata[`CF_OVERLAY];
      nxt_constrain = reg_wdata[`CF_CONSTRAIN];
      nxt_pal = reg_wdata[`CF_PAL];
      nxt_interlace = reg_wdata[`CF_INTERLACE];
      nxt_auto_std = reg_wdata[`CF_AUTO_STD];
      nxt_max_rate = reg_wdata[`CF_MAX_RATE];
      nxt_legacy_lock = reg_wdata[`CF_LEGACY_LOCK];
      nxt_crlf = reg_wdata[`CF_CRLF_LO +: 2];
      if (reg_wdata[`CF_SRC_LO +: 2] != 2'h0)
        nxt_src = overlay_cfg_pkg::src_mode_t'(reg_wdata[`CF_SRC_LO +: 2]);
    end
    if (reg_wr && reg_addr == `OFS_PIXEL && reg_wdata[3:0] <= 4'h8)
      nxt_pixsel = reg_wdata[3:0];
    if (det_valid && auto_std_ff && local_active && det_pal != pal_ff && !is_cfg)
    begin
      nxt_pal = det_pal;
      nxt_save = 1'b1;
    end
  end

  // Effective window from requests and current mode
  always_comb
  begin
    nxt_ppl = pix_per_line(rate_khz(pixsel_ff, max_rate_ff, pal_ff));
    lines_total = pal_ff ? `VLINES_PAL : `VLINES_NTSC;
    vdef = pal_ff ? `VSIZE_DEF_PAL : `VSIZE_DEF_NTSC;
    hlim = shrink(nxt_ppl, constrain_ff) & `HSIZE_STEP_MASK;
    nxt_hstart = pick(hstart_req_ff, `HSTART_DEF, `HSTART_MAX);
    nxt_hsize = pick(hsize_req_ff, `HSIZE_DEF, hlim) & `HSIZE_STEP_MASK;
    nxt_vstart = pick(vstart_req_ff, `VSTART_DEF, `VSTART_MAX);
    nxt_vsize = pick(vsize_req_ff, vdef, constrain_ff ? vdef : lines_total);
    nxt_cfg_word = cur_cfg;
  end

  // no clear or mode change touches crawl state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      overlay_ff <= 1'b1;
      constrain_ff <= 1'b1;
      pal_ff <= 1'b0;
      interlace_ff <= 1'b0;
      auto_std_ff <= 1'b1;
      max_rate_ff <= 1'b1;
      legacy_lock_ff <= 1'b1;
      crlf_ff <= 2'h0;
      src_ff <= overlay_cfg_pkg::SRC_AUTO;
      pixsel_ff <= 4'h0;
      hstart_req_ff <= 10'h000;
      hsize_req_ff <= 10'h000;
      vstart_req_ff <= 10'h000;
      vsize_req_ff <= 10'h000;
      boot_len_ff <= 10'h000;
      save_ff <= 1'b0;
      factory_ff <= 1'b0;
      boot_copy_ff <= 1'b0;
      crawl_copy_ff <= 1'b0;
      crawl_on_ff <= 1'b0;
      crawl_line_ff <= `CRAWL_DEF_LINE;
      crawl_rate_ff <= `CRAWL_DEF_RATE;
      crawl_gap_ff <= `CRAWL_DEF_GAP;
      crawl_reps_ff <= 16'h0000;
      crawl_forever_ff <= 1'b1;
      crawl_font_ff <= 4'h0;
      crawl_render_ff <= 7'h00;
      ppl_ff <= 10'h000;
      hstart_ff <= `HSTART_DEF;
      hsize_ff <= `HSIZE_DEF;
      vstart_ff <= `VSTART_DEF;
      vsize_ff <= `VSIZE_DEF_NTSC;
      cfg_word_ff <= 16'h0000;
    end
    else
    begin
      overlay_ff <= nxt_overlay;
      constrain_ff <= nxt_constrain;
      pal_ff <= nxt_pal;
      interlace_ff <= nxt_interlace;
      auto_std_ff <= nxt_auto_std;
      max_rate_ff <= nxt_max_rate;
      legacy_lock_ff <= nxt_legacy_lock;
      crlf_ff <= nxt_crlf;
      src_ff <= nxt_src;
      pixsel_ff <= nxt_pixsel;
      hstart_req_ff <= nxt_hstart_req;
      hsize_req_ff <= nxt_hsize_req;
      vstart_req_ff <= nxt_vstart_req;
      vsize_req_ff <= nxt_vsize_req;
      boot_len_ff <= nxt_boot_len;
      save_ff <= nxt_save;
      factory_ff <= nxt_factory;
      boot_copy_ff <= nxt_boot_copy;
      crawl_copy_ff <= nxt_crawl_copy;
      crawl_on_ff <= nxt_crawl_on;
      crawl_line_ff <= nxt_crawl_line;
      crawl_rate_ff <= nxt_crawl_rate;
      crawl_gap_ff <= nxt_crawl_gap;
      crawl_reps_ff <= nxt_crawl_reps;
      crawl_forever_ff <= nxt_crawl_forever;
      crawl_font_ff <= nxt_crawl_font;
      crawl_render_ff <= nxt_crawl_render;
      ppl_ff <= nxt_ppl;
      hstart_ff <= nxt_hstart;
      hsize_ff <= nxt_hsize;
      vstart_ff <= nxt_vstart;
      vsize_ff <= nxt_vsize;
      cfg_word_ff <= nxt_cfg_word;
    end
  end

  // ==========
  // Character stream and register read port
  logic pend_clr_ff, nxt_pend_clr;
  logic out_valid_ff, nxt_out_valid;
  logic [7:0] out_data_ff, nxt_out_data;
  logic out_cr_ff, nxt_out_cr;
  logic out_lf_ff, nxt_out_lf;
  logic clear_ff, nxt_clear;
  logic [31:0] rdata_ff, nxt_rdata;
  logic live_char;

  assign live_char = char_valid && char_data != `CHAR_NUL;

  // Deferred clear, CR and LF mapping, read mux
  always_comb
  begin
    nxt_pend_clr = pend_clr_ff;
    nxt_clear = 1'b0;
    nxt_out_valid = live_char;
    nxt_out_data = char_data;
    nxt_out_cr = 1'b0;
    nxt_out_lf = 1'b0;
    if (live_char && pend_clr_ff)
    begin
      nxt_clear = 1'b1;
      nxt_pend_clr = 1'b0;
    end
    if (cmd_valid && op == overlay_cfg_pkg::OP_DEFER_CLEAR)
      nxt_pend_clr = 1'b1;
    if (live_char && char_data == `CHAR_CR)
    begin
      nxt_out_cr = 1'b1;
      nxt_out_lf = crlf_ff[0];
    end
    if (live_char && char_data == `CHAR_LF)
    begin
      nxt_out_lf = 1'b1;
      nxt_out_cr = crlf_ff[1];
    end
    nxt_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `OFS_CONFIG: nxt_rdata = {16'h0000, cfg_word_ff};
        `OFS_PIXEL: nxt_rdata = {6'h00, ppl_ff, 12'h000, pixsel_ff};
        `OFS_HWIN: nxt_rdata = {6'h00, hsize_ff, 6'h00, hstart_ff};
        `OFS_VWIN: nxt_rdata = {6'h00, vsize_ff, 6'h00, vstart_ff};
        `OFS_CRAWL: nxt_rdata = {crawl_line_ff, 6'h00, pend_clr_ff, crawl_forever_ff,
                                 crawl_on_ff, crawl_gap_ff};
        `OFS_BOOT: nxt_rdata = {22'h00_0000, boot_len_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Stream and read registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pend_clr_ff <= 1'b0;
      clear_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
      out_cr_ff <= 1'b0;
      out_lf_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pend_clr_ff <= nxt_pend_clr;
      clear_ff <= nxt_clear;
      out_valid_ff <= nxt_out_valid;
      out_data_ff <= nxt_out_data;
      out_cr_ff <= nxt_out_cr;
      out_lf_ff <= nxt_out_lf;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign out_cr = out_cr_ff;
  assign out_lf = out_lf_ff;
  assign clear_screen = clear_ff;
  assign crawl_copy = crawl_copy_ff;
  assign boot_copy = boot_copy_ff;
  assign boot_len = boot_len_ff;
  assign flash_save = save_ff;
  assign factory_load = factory_ff;
  assign crawl_on = crawl_on_ff;
  assign crawl_line = crawl_line_ff;
  assign crawl_rate = crawl_rate_ff;
  assign crawl_gap = crawl_gap_ff;
  assign crawl_reps = crawl_reps_ff;
  assign crawl_forever = crawl_forever_ff;
  assign crawl_font = crawl_font_ff;
  assign crawl_render = crawl_render_ff;
  assign cfg_word = cfg_word_ff;
  assign pixel_clock_select = pixsel_ff;
  assign line_pixels = ppl_ff;
  assign hstart = hstart_ff;
  assign hsize = hsize_ff;
  assign vstart = vstart_ff;
  assign vsize = vsize_ff;

endmodule

// [include/overlay_cfg_regs.svh]
`ifndef OVERLAY_CFG_REGS_SVH
`define OVERLAY_CFG_REGS_SVH

// ==========
// Register offsets (byte addresses, one word each)
`define OFS_CONFIG 5'h00
`define OFS_PIXEL 5'h04
`define OFS_HWIN 5'h08
`define OFS_VWIN 5'h0C
`define OFS_CRAWL 5'h10
`define OFS_BOOT 5'h14

// ==========
// Config word field positions
`define CF_OVERLAY 0
`define CF_CONSTRAIN 1
`define CF_PAL 2
`define CF_INTERLACE 3
`define CF_AUTO_STD 4
`define CF_MAX_RATE 5
`define CF_LEGACY_LOCK 6
`define CF_CRLF_LO 8
`define CF_SRC_LO 12

// ==========
// Configuration selectors
`define SEL_SAVE 8'h01
`define SEL_FACTORY 8'h02
`define SEL_BOOT 8'h08
`define SEL_LEGACY 8'h09
`define SEL_CRLF 8'h0B
`define SEL_STD 8'h10
`define SEL_SCAN 8'h11
`define SEL_SOURCE 8'h12
`define SEL_AUTO_STD 8'h13
`define SEL_MAX_RATE 8'h14
`define SEL_CONSTRAIN 8'h15
`define SEL_PIXSEL 8'h17
`define SEL_HSTART 8'h18
`define SEL_HSIZE 8'h19
`define SEL_VSTART 8'h1A
`define SEL_VSIZE 8'h1B
`define SEL_OVERLAY 8'h1C

// ==========
// Crawl defaults
`define CRAWL_DEF_LINE (-16'sd22)
`define CRAWL_DEF_RATE 16'h0002
`define CRAWL_DEF_GAP 7'h46
`define CRAWL_GAP_MAX 7'h64

// ==========
// Window defaults and limits
`define HSTART_DEF 10'h074
`define HSIZE_DEF 10'h1A0
`define VSTART_DEF 10'h027
`define VSIZE_DEF_NTSC 10'h0D0
`define VSIZE_DEF_PAL 10'h0F8
`define VLINES_NTSC 10'h0F0
`define VLINES_PAL 10'h120
`define HSTART_MAX 10'h0C8
`define VSTART_MAX 10'h040
`define CONSTRAIN_PCT 8'h57
`define HSIZE_STEP_MASK 10'h3F0

// ==========
// Pixel rates in kHz; pixels per line = rate * 64 / 1250
`define PPL_MUL 8'h40
`define PPL_DIV 12'h4E2
`define RATE_NTSC_KHZ 14'd6250
`define RATE_PAL_KHZ 14'd7500
`define RATE_MAX_KHZ 14'd9375

// ==========
// Boot script and misc
`define BOOT_MAX_LEN 10'h384
`define CHAR_NUL 8'h00
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A

`endif

// [include/overlay_cfg_pkg.sv]
package overlay_cfg_pkg;

  // Decoded command kinds from the escape parser
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CRAWL,
    OP_DEFER_CLEAR,
    OP_CONFIG
  } cmd_op_t;

  // Video source policy
  typedef enum logic [1:0] {
    SRC_RSVD,
    SRC_LOCAL,
    SRC_REMOTE,
    SRC_AUTO
  } src_mode_t;

endpackage

// [tb/overlay_cmd_checker.sv]
`timescale 1ns/1ps
// ==========
// Port checks of the command handler
module overlay_cmd_checker (
  // Clock, reset and requests
  input wire logic ref_clk, rst, cmd_valid, char_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_argc,
  input wire logic [15:0] cmd_arg0,
  input wire logic [7:0] char_data,
  input wire logic [9:0] str_len,
  input wire logic [3:0] cur_font,
  // Results
  input wire logic out_valid, out_cr, out_lf, clear_screen, crawl_copy, crawl_on, flash_save,
  input wire logic [3:0] crawl_font,
  input wire logic [9:0] boot_len,
  input wire logic [15:0] cfg_word
);
  logic pend_ff;
  logic nxt_pend;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Deferred clear waits for a non-NUL byte
  always_comb
  begin
    nxt_pend = pend_ff;
    if (cmd_valid && cmd_op == 2'h2)
      nxt_pend = 1'b1;
    else if (char_valid && char_data != 8'h00)
      nxt_pend = 1'b0;
  end
  always_ff @(posedge ref_clk)
  begin
    pend_ff <= rst ? 1'b0 : nxt_pend;
  end
  // ==========
  // Assertions
  crawl_start_a: assert property (
    cmd_valid && cmd_op == 2'h1 && str_len != 10'h000 && (cmd_argc == 3'h0 || cmd_arg0 != 16'h0000)
    |=> crawl_copy && crawl_on) else $error("crawl start lost");
  empty_crawl_a: assert property (
    cmd_valid && cmd_op == 2'h1 && str_len == 10'h000 |=> !crawl_on && !crawl_copy)
    else $error("empty crawl ran");
  font_latch_a: assert property (crawl_copy |-> crawl_font == $past(cur_font))
    else $error("font not latched");
  font_hold_a: assert property (!crawl_copy |-> $stable(crawl_font))
    else $error("crawl font moved");
  nul_drop_a: assert property (
    char_valid && char_data == 8'h00 |=> !out_valid && !clear_screen) else $error("NUL passed");
  clear_trigger_a: assert property (
    pend_ff && char_valid && char_data != 8'h00 |=> clear_screen && out_valid)
    else $error("deferred clear missing");
  save_flash_a: assert property (
    cmd_valid && cmd_op == 2'h3 && cmd_arg0 == 16'h0001 |=> flash_save) else $error("no save");
  boot_limit_a: assert property (boot_len <= 10'h384)
    else $error("boot script too long");
  cr_action_a: assert property (
    char_valid && char_data == 8'h0D |=> out_cr && out_lf == cfg_word[8]) else $error("CR wrong");
  cover property (crawl_copy);
  cover property (clear_screen);
  cover property (flash_save);
endmodule

// [tb/host_link.sv]
`timescale 1ns/1ps
// ==========
// Host side: commands and characters
module host_link (
  // Clock
  input wire logic ref_clk,
  // Command and character lines
  output logic cmd_valid, char_valid,
  output logic [1:0] cmd_op,
  output logic [2:0] cmd_argc,
  output logic [15:0] cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4,
  output logic [7:0] char_data
);
  // Idle at time zero
  initial
  begin
    {cmd_valid, char_valid, cmd_op, cmd_argc, char_data} = '0;
    {cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4} = '0;
  end
  // One command; released arguments show their inverse
  task automatic cmd(input logic [1:0] op, input logic [2:0] n, input logic [15:0] a0 = '0,
    input logic [15:0] a1 = '0, input logic [15:0] a2 = '0,
    input logic [15:0] a3 = '0, input logic [15:0] a4 = '0);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_argc <= n;
    {cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4} <= {a0, a1, a2, a3, a4};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    {cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4} <= ~{a0, a1, a2, a3, a4};
    #1;
  endtask
  // One printable byte
  task automatic chr(input logic [7:0] c);
    @(posedge ref_clk);
    char_valid <= 1'b1;
    char_data <= c;
    @(posedge ref_clk);
    char_valid <= 1'b0;
    char_data <= ~c;
    #1;
  endtask
  // Config command, selector and value
  task automatic cfg(input int n, input int v);
    cmd(2'h3, 3'h2, 16'(n), 16'(v));
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
// ==========
// Bench for the command handler
module testbench;
  logic ref_clk, rst, cmd_valid, char_valid, det_valid, det_pal, local_active, reg_wr, reg_rd;
  logic out_valid, out_cr, out_lf, clear_screen, crawl_copy, boot_copy, flash_save;
  logic factory_load, crawl_on, crawl_forever;
  logic [1:0] cmd_op;
  logic [2:0] cmd_argc;
  logic [3:0] cur_font, crawl_font, pixel_clock_select;
  logic [4:0] reg_addr;
  logic [6:0] cur_render, crawl_render, crawl_gap;
  logic [7:0] char_data, out_data, c;
  logic [9:0] str_len, boot_len, line_pixels, hstart, hsize, vstart, vsize;
  logic [15:0] cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3, cmd_arg4, crawl_line, crawl_rate;
  logic [15:0] crawl_reps, cfg_word;
  logic [31:0] reg_wdata, reg_rdata;
  int n_fail, checked, m, khz[$], sel[$], bitp[$];
  host_link i_host (.ref_clk, .cmd_valid, .char_valid, .cmd_op, .cmd_argc, .cmd_arg0,
    .cmd_arg1, .cmd_arg2, .cmd_arg3, .cmd_arg4, .char_data);
  overlay_config_crawl_cmd i_dut (.*);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register writes and reads
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang limit
  initial
  begin
    #1000000;
    n_fail++;
    results();
  end
  // Main sequence
  initial
  begin
    {rst, det_valid, det_pal, local_active, reg_wr, reg_rd} = 6'h20;
    {reg_addr, reg_wdata, str_len, cur_font, cur_render} = '0;
    khz = '{5000, 5375, 5769, 6250, 6818, 7500, 8330, 9375};
    sel = '{28, 21, 17, 19, 9};
    bitp = '{0, 1, 3, 4, 6};
    void'($urandom(3026));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk({crawl_on, crawl_forever, crawl_line}, {2'b01, 16'hFFEA});
    chk({crawl_rate, crawl_gap}, {16'h0002, 7'h46});
    chk({line_pixels, hstart, hsize}, {10'h1E0, 10'h074, 10'h1A0});
    chk({vstart, vsize}, {10'h027, 10'h0D0});
    rd(5'h00, 32'h3073);
    rd(5'h1C, 32'h0);
    // Crawl start, latch and survival
    c = 8'($urandom);
    {str_len, cur_font, cur_render} <= {10'h005, c[3:0], c[6:0]};
    i_host.cmd(2'h1, 3'h0);
    chk({crawl_copy, crawl_on, crawl_font}, {2'b11, c[3:0]});
    cur_font <= ~c[3:0];
    i_host.cfg(16, 1);
    i_host.cfg(27, 0);
    settle();
    chk({crawl_on, crawl_font, vsize}, {1'b1, c[3:0], 10'h0F8});
    i_host.cmd(2'h1, 3'h5, 16'h0001, 16'hFFF0, 16'h0003, 16'h0064, 16'h0004);
    chk({crawl_line, crawl_rate, crawl_reps}, {16'hFFF0, 16'h0003, 16'h0004});
    chk({crawl_gap, crawl_forever}, {7'h64, 1'b0});
    i_host.cmd(2'h1, 3'h1);
    chk(crawl_on, 1'b0);
    i_host.cmd(2'h1, 3'h0);
    str_len <= 10'h000;
    i_host.cmd(2'h1, 3'h0);
    chk({crawl_on, crawl_copy}, 2'b00);
    // Deferred clear
    i_host.cmd(2'h2, 3'h0);
    i_host.chr(8'h00);
    chk(out_valid, 1'b0);
    c = 8'h20 + 8'($urandom_range(94));
    i_host.chr(c);
    chk({clear_screen, out_valid, out_data}, {2'b11, c});
    // Line ending modes
    for (m = 0; m < 4; m++)
    begin
      i_host.cfg(11, m);
      i_host.chr(8'h0D);
      chk({out_cr, out_lf}, {1'b1, m[0]});
      i_host.chr(8'h0A);
      chk({out_cr, out_lf}, {m[1], 1'b1});
    end
    // Flag selectors, then source policy
    foreach (sel[i])
      for (m = 0; m < 2; m++)
      begin
        i_host.cfg(sel[i], m);
        settle();
        chk(cfg_word[bitp[i]], m[0]);
      end
    for (m = 1; m < 4; m++)
    begin
      i_host.cfg(18, m);
      settle();
      chk(cfg_word[13:12], m[1:0]);
    end
    // Window width step and default start
    i_host.cfg(25, 100);
    i_host.cfg(24, 0);
    settle();
    chk({hsize, hstart}, {10'h060, 10'h074});
    // Pixel clock codes
    foreach (khz[i])
    begin
      wr(5'h04, 32'(i + 1));
      settle();
      chk(line_pixels, khz[i] * 64 / 1250);
    end
    wr(5'h04, 32'h0);
    settle();
    chk(line_pixels, 10'h1E0);
    i_host.cfg(20, 0);
    settle();
    chk(line_pixels, 10'h180);
    // Local mode adopts the detected standard
    {det_valid, local_active} <= 2'h3;
    settle();
    det_valid <= 1'b0;
    chk({cfg_word[2], line_pixels}, {1'b0, 10'h140});
    // Save, boot capture, factory restore
    i_host.cfg(1, 0);
    chk(flash_save, 1'b1);
    str_len <= 10'h3B6;
    i_host.cfg(8, 0);
    chk({boot_copy, boot_len}, {1'b1, 10'h384});
    i_host.cfg(2, 0);
    chk(factory_load, 1'b1);
    settle();
    rd(5'h14, 32'h0);
    rd(5'h00, 32'h3073);
    results();
  end
endmodule
bind overlay_config_crawl_cmd overlay_cmd_checker i_chk (.*);
